//--- src/cbscc_pkg.sv
// package of constants and types for the cell balance and charge short-circuit block
package cbscc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] CBSCC_ADDR_GAIN    = 8'h07;
  localparam logic [7:0] CBSCC_ADDR_SHORT   = 8'h09;
  localparam logic [7:0] CBSCC_ADDR_BALANCE = 8'h0a;
  localparam logic [7:0] CBSCC_ADDR_STATUS  = 8'h20;
  localparam logic [7:0] CBSCC_ADDR_IRQ     = 8'h21;
  localparam logic [7:0] CBSCC_ADDR_MASK    = 8'h22;
  localparam logic [7:0] CBSCC_ADDR_LIMITS  = 8'h23;
  // field positions
  localparam int CBSCC_GAIN_BIT   = 0;
  localparam int CBSCC_MODE_LSB   = 6;
  localparam int CBSCC_TMO_LSB    = 4;
  localparam int CBSCC_THR_LSB    = 0;
  localparam int CBSCC_SDLY_LSB   = 4;
  localparam int CBSCC_STRIP_LSB  = 0;
  // reset values
  localparam logic [7:0] CBSCC_BALANCE_RST = 8'h00;
  localparam logic [7:0] CBSCC_SHORT_RST   = 8'h10;
  localparam logic [7:0] CBSCC_GAIN_RST    = 8'h00;
  localparam logic [2:0] CBSCC_MASK_RST    = 3'h0;
  // timing and millivolt levels
  localparam int CBSCC_CLK_MHZ        = 100;
  localparam int CBSCC_DELAY_BASE_US  = 120;
  localparam int CBSCC_DELAY_STEP_US  = 60;
  localparam int CBSCC_US_CYCLES      = CBSCC_CLK_MHZ;
  localparam int CBSCC_HOUR_S         = 3600;
  localparam int CBSCC_TRIP_BASE_MV   = 10;
  localparam int CBSCC_TRIP_STEP_MV   = 5;
  localparam int CBSCC_TRIP_GAIN      = 5;
  localparam int CBSCC_THR_TOP_MV     = 3900;
  localparam int CBSCC_THR_STEP_MV    = 100;
  // balance modes and balance states
  typedef enum logic [1:0] {
    CBSCC_MODE_OFF, CBSCC_MODE_ALWAYS, CBSCC_MODE_CHG, CBSCC_MODE_CHG_TMO
  } cbscc_mode_t;
  typedef enum logic [1:0] {CBSCC_IDLE, CBSCC_BLEED, CBSCC_EXPIRED} cbscc_state_t;
endpackage

//--- src/cbscc_top.sv
// balance controller and charge short-circuit filter with register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module cbscc_top
  import cbscc_pkg::*;
#(
  parameter int CELLS        = 10,
  parameter int MV_W         = 13,
  parameter int SEC_CYCLES   = 100_000_000  // one second of clock cycles
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  // register port
  input  wire logic [7:0]           addr_in,
  input  wire logic [7:0]           wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [7:0]           rdata_out,
  // monitors
  input  wire logic [CELLS*MV_W-1:0] cell_mv_in,
  input  wire logic                 charger_in,
  input  wire logic [9:0]           sense_neg_mv_in,
  // outputs
  output logic      [CELLS-1:0]     bleed_out,
  output logic      [9:0]           trip_mv_out,
  output logic                      short_fault_out,
  output logic      [10:0]          max_ocd_ms_out,
  output logic      [10:0]          max_scd_ms_out,
  output logic                      irq_out
);
  // ==========================================================
  // registers
  logic [7:0] balance_q, short_q, gain_q;
  logic [2:0] irq_q, mask_q;
  logic       balancing_q, fault_q, bleed_begin, tmo_hit, fault_set;
  cbscc_state_t state_q;
  cbscc_mode_t  mode;
  logic [1:0]  tmo_sel;
  logic [3:0]  thr_code, dly_code, trip_code;
  logic [MV_W-1:0] max_mv, thr_mv;
  logic        at_thr, chg_q;

  // decoded fields of the configuration bytes
  assign mode      = cbscc_mode_t'(balance_q[CBSCC_MODE_LSB +: 2]);
  assign tmo_sel   = balance_q[CBSCC_TMO_LSB +: 2];
  assign thr_code  = balance_q[CBSCC_THR_LSB +: 4];
  assign dly_code  = short_q[CBSCC_SDLY_LSB +: 4];
  assign trip_code = short_q[CBSCC_STRIP_LSB +: 4];

  // threshold code to millivolts
  function automatic logic [MV_W-1:0] thr_decode(input logic [3:0] c);
    thr_decode = MV_W'(CBSCC_THR_TOP_MV - CBSCC_THR_STEP_MV * int'(c));
  endfunction

  // ==========================================================
  // register writes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      balance_q <= CBSCC_BALANCE_RST;
      short_q   <= CBSCC_SHORT_RST;
      gain_q    <= CBSCC_GAIN_RST;
      mask_q    <= CBSCC_MASK_RST;
    end else if (wr_in) begin
      unique case (addr_in)
        CBSCC_ADDR_BALANCE: balance_q <= wdata_in;
        CBSCC_ADDR_SHORT:   short_q <= wdata_in;
        CBSCC_ADDR_GAIN:    gain_q <= wdata_in;
        CBSCC_ADDR_MASK:    mask_q <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        CBSCC_ADDR_BALANCE: rdata_out <= balance_q;
        CBSCC_ADDR_SHORT:   rdata_out <= short_q;
        CBSCC_ADDR_GAIN:    rdata_out <= gain_q;
        CBSCC_ADDR_STATUS:  rdata_out <= {5'h00, state_q == CBSCC_EXPIRED, fault_q, balancing_q};
        CBSCC_ADDR_IRQ:     rdata_out <= {5'h00, irq_q};
        CBSCC_ADDR_MASK:    rdata_out <= {5'h00, mask_q};
        CBSCC_ADDR_LIMITS:  rdata_out <= {7'h00, mode[1]};
        default:            rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ==========================================================
  // highest cell against threshold
  always_comb begin
    max_mv = '0;
    for (int i = 0; i < CELLS; i++) begin
      if (cell_mv_in[i*MV_W +: MV_W] > max_mv) begin
        max_mv = cell_mv_in[i*MV_W +: MV_W];
      end
    end
  end
  assign thr_mv = thr_decode(thr_code);
  assign at_thr = max_mv >= thr_mv;

  // ==========================================================
  // seconds tick and hour timer; timeout counts only while bleeding
  localparam int SEC_W = $clog2(SEC_CYCLES + 1);
  logic [SEC_W-1:0] sec_cnt_q;
  logic [15:0]      secs_q;
  logic             sec_tick;
  logic [15:0]      tmo_secs;
  assign sec_tick = sec_cnt_q == SEC_W'(SEC_CYCLES - 1);
  assign tmo_secs = 16'(CBSCC_HOUR_S << tmo_sel);
  // mode 10 has no timeout, so it must not raise the timeout event either
  assign tmo_hit  = balancing_q && sec_tick && (mode != CBSCC_MODE_CHG)
                    && (secs_q + 16'h0001 >= tmo_secs);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sec_cnt_q <= '0;
      secs_q    <= 16'h0000;
    end else if (!balancing_q) begin
      sec_cnt_q <= '0;
      secs_q    <= 16'h0000;
    end else if (sec_tick) begin
      sec_cnt_q <= '0;
      secs_q    <= secs_q + 16'h0001;
    end else begin
      sec_cnt_q <= sec_cnt_q + SEC_W'(1);
    end
  end

  // ==========================================================
  // balance state machine
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chg_q <= 1'b0;
    end else begin
      chg_q <= charger_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= CBSCC_IDLE;
    end else begin
      unique case (state_q)
        CBSCC_IDLE: begin
          if (mode == CBSCC_MODE_ALWAYS && at_thr) begin
            state_q <= CBSCC_BLEED;
          end else if (mode[1] && charger_in && at_thr) begin
            state_q <= CBSCC_BLEED;
          end
        end
        CBSCC_BLEED: begin
          if (mode == CBSCC_MODE_OFF) begin
            state_q <= CBSCC_IDLE;
          end else if (mode[1] && !charger_in) begin
            state_q <= CBSCC_IDLE;
          end else if (tmo_hit && mode != CBSCC_MODE_CHG) begin
            state_q <= CBSCC_EXPIRED;
          end
        end
        CBSCC_EXPIRED: begin
          if (mode == CBSCC_MODE_OFF || mode == CBSCC_MODE_CHG) begin
            state_q <= CBSCC_IDLE;
          end else if (mode == CBSCC_MODE_ALWAYS && !at_thr) begin
            state_q <= CBSCC_IDLE;
          end else if (mode == CBSCC_MODE_CHG_TMO && !charger_in && chg_q) begin
            state_q <= CBSCC_IDLE;
          end
        end
        default: state_q <= CBSCC_IDLE;
      endcase
    end
  end

  // bleed a cell while balancing and it sits at or above threshold
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bleed_out   <= '0;
      balancing_q <= 1'b0;
    end else begin
      balancing_q <= state_q == CBSCC_BLEED;
      for (int i = 0; i < CELLS; i++) begin
        bleed_out[i] <= (state_q == CBSCC_BLEED) && (cell_mv_in[i*MV_W +: MV_W] >= thr_mv);
      end
    end
  end
  assign bleed_begin = (state_q == CBSCC_BLEED) && !balancing_q;

  // discharge delay limits follow the balancing mode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      max_ocd_ms_out <= 11'd2000;
      max_scd_ms_out <= 11'd1500;
    end else begin
      max_ocd_ms_out <= mode[1] ? 11'd180 : 11'd2000;
      max_scd_ms_out <= mode[1] ? 11'd100 : 11'd1500;
    end
  end

  // ==========================================================
  // charge short-circuit trip level and delay filter
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trip_mv_out <= 10'h000;
    end else begin
      trip_mv_out <= 10'((CBSCC_TRIP_BASE_MV + CBSCC_TRIP_STEP_MV * int'(trip_code))
                         * (gain_q[CBSCC_GAIN_BIT] ? CBSCC_TRIP_GAIN : 1));
    end
  end

  // delay in cycles; doubled while balancing, which the fault side tolerates
  logic [18:0] dly_cycles, sc_cnt_q;
  logic        over;
  assign dly_cycles = 19'((CBSCC_DELAY_BASE_US + CBSCC_DELAY_STEP_US * (int'(dly_code) - 1))
                          * CBSCC_US_CYCLES) << balancing_q;
  assign over = (sense_neg_mv_in >= trip_mv_out) && (dly_code != 4'h0);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sc_cnt_q <= '0;
      fault_q  <= 1'b0;
    end else if (!over) begin
      sc_cnt_q <= '0;
      fault_q  <= 1'b0;
    end else if (sc_cnt_q + 19'd1 >= dly_cycles) begin
      fault_q  <= 1'b1;
    end else begin
      sc_cnt_q <= sc_cnt_q + 19'd1;
    end
  end
  assign short_fault_out = fault_q;
  assign fault_set       = over && !fault_q && (sc_cnt_q + 19'd1 >= dly_cycles);

  // ==========================================================
  // sticky events: bleed start, timeout, fault; write one to clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_q <= 3'h0;
    end else begin
      irq_q <= (irq_q & ~((wr_in && addr_in == CBSCC_ADDR_IRQ) ? wdata_in[2:0] : 3'h0))
               | {fault_set, tmo_hit, bleed_begin};  // set wins
    end
  end
  assign irq_out = |(irq_q & mask_q);
endmodule
`default_nettype wire

//--- verification/cbscc_sva.sv
// checker for the cell balance and charge short-circuit block
`timescale 1ns/1ns
`default_nettype none
module cbscc_sva
  import cbscc_pkg::*;
#(parameter int CELLS = 10, parameter int MV_W = 13) (
  // watched ports
  input wire logic             clk_in,
  input wire logic             reset_n_in,
  input wire logic [7:0]       addr_in,
  input wire logic [7:0]       wdata_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [7:0]       rdata_out,
  input wire logic             charger_in,
  input wire logic [9:0]       sense_neg_mv_in,
  input wire logic [CELLS-1:0] bleed_out,
  input wire logic [9:0]       trip_mv_out,
  input wire logic             short_fault_out,
  input wire logic [10:0]      max_ocd_ms_out,
  input wire logic [10:0]      max_scd_ms_out
);
  logic [7:0]  bal_q, shc_q;
  logic        gain_q;
  logic [3:0]  quiet_q;
  logic [15:0] over_q;
  wire         over = sense_neg_mv_in >= trip_mv_out;
  wire [9:0]   trip_exp = (10'h00a + 10'h005 * shc_q[3:0]) * (gain_q ? 10'h005 : 10'h001);
  // ==========================================================
  // shadow of written registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bal_q <= CBSCC_BALANCE_RST;
      shc_q <= CBSCC_SHORT_RST;
      gain_q <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == CBSCC_ADDR_BALANCE) bal_q <= wdata_in;
      if (addr_in == CBSCC_ADDR_SHORT) shc_q <= wdata_in;
      if (addr_in == CBSCC_ADDR_GAIN) gain_q <= wdata_in[0];
    end
  end
  // settle count: decode latency is the designer's, so wait it out
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) quiet_q <= 4'h0;
    else quiet_q <= wr_in ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
  end
  // consecutive cycles beyond the trip level
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) over_q <= 16'h0000;
    else over_q <= !over ? 16'h0000 : over_q + {15'h0000, over_q != 16'hffff};
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  rdata_bal_a: assert property ($past(rd_in && addr_in == CBSCC_ADDR_BALANCE)
    |-> rdata_out == $past(bal_q)) else $error("balance readback wrong");
  trip_level_a: assert property (quiet_q >= 4'h3 |-> trip_mv_out == trip_exp)
    else $error("trip level decode wrong");
  limit_mode_a: assert property (quiet_q >= 4'h3 |-> max_ocd_ms_out ==
    (bal_q[7] ? 11'h00b4 : 11'h07d0) && max_scd_ms_out == (bal_q[7] ? 11'h0064 : 11'h05dc))
    else $error("delay limits wrong");
  fault_delay_a: assert property ($rose(short_fault_out) |-> over_q >= 16'h2ec6)
    else $error("fault before delay");
  fault_clear_a: assert property (!over [*3] |-> !short_fault_out)
    else $error("fault held without cause");
  bleed_off_a: assert property ((bal_q[7:6] == 2'h0) [*3] |-> bleed_out == '0)
    else $error("bleed while disabled");
  bleed_charger_a: assert property ((bal_q[7] && !charger_in) [*3] |-> bleed_out == '0)
    else $error("bleed without charger");
  cover property ($rose(short_fault_out));
  cover property ($rose(|bleed_out));
  cover property ($fell(|bleed_out) && charger_in);
endmodule
bind cbscc_top cbscc_sva #(.CELLS(CELLS), .MV_W(MV_W)) u_sva (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .charger_in(charger_in),
  .sense_neg_mv_in(sense_neg_mv_in), .bleed_out(bleed_out), .trip_mv_out(trip_mv_out),
  .short_fault_out(short_fault_out), .max_ocd_ms_out(max_ocd_ms_out),
  .max_scd_ms_out(max_scd_ms_out));
`default_nettype wire

//--- verification/cbscc_cells.sv
// partner model: cell monitors, charger detector and sense comparator
`timescale 1ns/1ns
`default_nettype none
module cbscc_cells #(parameter int CELLS = 4) (
  // requests from the bench
  input  wire logic [12:0]        top_mv_in,
  input  wire logic               plug_in,
  input  wire logic [9:0]         sense_in,
  // monitor outputs
  output logic [CELLS*13-1:0]     cell_mv_out,
  output logic                    charger_out,
  output logic [9:0]              sense_neg_mv_out
);
  // cell 0 is highest, the rest sit 50 mV lower
  always_comb begin
    for (int i = 0; i < CELLS; i++) begin
      cell_mv_out[i*13 +: 13] = (i == 0) ? top_mv_in : top_mv_in - 13'h0032;
    end
  end
  assign charger_out = plug_in;
  assign sense_neg_mv_out = sense_in;
endmodule
`default_nettype wire

//--- verification/tb_cbscc_top.sv
// self-checking bench for the cell balance and charge short-circuit block
`timescale 1ns/1ns
`default_nettype none
module tb_cbscc_top;
  localparam int CELLS = 4;
  logic             clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0]       addr_in = 8'h00, wdata_in = 8'h00, rdata_out, d;
  logic [CELLS*13-1:0] cell_mv;
  logic             charger, plug = 1'b0, short_fault_out, irq_out, a;
  logic [9:0]       sense, sense_req = 10'h000, trip_mv_out;
  logic [12:0]      top_mv = 13'h0bb8;
  logic [CELLS-1:0] bleed_out;
  logic [10:0]      discharge_overcurrent, discharge_short_circuit;
  int               err_total = 0, checked = 0, n;
  always #5 clk_in = ~clk_in;
  cbscc_top #(.CELLS(CELLS), .SEC_CYCLES(5)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cell_mv_in(cell_mv), .charger_in(charger),
    .sense_neg_mv_in(sense), .bleed_out(bleed_out), .trip_mv_out(trip_mv_out),
    .short_fault_out(short_fault_out), .max_ocd_ms_out(discharge_overcurrent), .max_scd_ms_out(discharge_short_circuit),
    .irq_out(irq_out));
  cbscc_cells #(.CELLS(CELLS)) cells (.top_mv_in(top_mv), .plug_in(plug),
    .sense_in(sense_req), .cell_mv_out(cell_mv), .charger_out(charger),
    .sense_neg_mv_out(sense));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // bounded wait on bleed (f=0) or fault (f=1); n holds the cycles spent
  task automatic wait_on(input bit f, input logic v, input int max);
    n = 0;
    while ((f ? short_fault_out : |bleed_out) !== v && n < max) begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(8'h0a);
    chk(d, 8'h00);
    rd(8'h09);
    chk(d, 8'h10);
    rd(8'h05);
    chk(d, 8'h00);
    chk(discharge_overcurrent, 11'h07d0);
    chk(discharge_short_circuit, 11'h05dc);
  endtask
  task automatic t_trip;
    for (int g = 0; g < 2; g++) begin
      wr(8'h07, 8'(g));
      for (int c = 0; c < 16; c++) begin
        wr(8'h09, 8'h10 | 8'(c));
        repeat (3) @(posedge clk_in);
        chk(trip_mv_out, 16'((10 + 5 * c) * (g ? 5 : 1)));
      end
    end
  endtask
  task automatic t_short;
    wr(8'h09, 8'h11);
    sense_req <= 10'h0c8;
    wait_on(1, 1, 13000);
    chk(16'(n >= 11990 && n <= 12010), 1);
    sense_req <= 10'h000;
    wait_on(1, 0, 5);
    chk(short_fault_out, 0);
    sense_req <= 10'h0c8;
    repeat (6000) @(posedge clk_in);
    sense_req <= 10'h000;
    repeat (2) @(posedge clk_in);
    sense_req <= 10'h0c8;
    wait_on(1, 1, 13000);
    chk(16'(n >= 11990), 1);
    sense_req <= 10'h000;
  endtask
  task automatic t_mode1;
    top_mv <= 13'h0e0f;
    wr(8'h0a, 8'h43);
    rd(8'h0a);
    chk(d, 8'h43);
    repeat (20) @(posedge clk_in);
    chk(|bleed_out, 0);
    top_mv <= 13'h0e10;
    wait_on(0, 1, 5);
    chk(bleed_out[0], 1);
    wait_on(0, 0, 18100);
    chk(16'(n > 17950 && n < 18020), 1);
    repeat (50) @(posedge clk_in);
    chk(|bleed_out, 0);
    top_mv <= 13'h0dac;
    repeat (5) @(posedge clk_in);
    top_mv <= 13'h0e10;
    wait_on(0, 1, 5);
    chk(|bleed_out, 1);
    rd(8'h21);
    chk(d & 8'h01, 1);
    wr(8'h22, 8'h00);
    #1 a = irq_out;
    wr(8'h22, 8'h07);
    #1 chk(a ^ irq_out, 1);
    wr(8'h21, 8'h07);
    rd(8'h21);
    chk(irq_out, 0);
    wr(8'h0a, 8'h00);
  endtask
  task automatic t_mode3;
    top_mv <= 13'h0bb8;
    wr(8'h0a, 8'hcf);
    repeat (20) @(posedge clk_in);
    chk(|bleed_out, 0);
    chk({discharge_overcurrent, 5'h00} | 16'(discharge_short_circuit), 16'h16e4);
    rd(8'h23);
    chk(d, 8'h01);
    plug <= 1'b1;
    wait_on(0, 1, 5);
    chk(|bleed_out, 1);
    sense_req <= 10'h0c8;
    wait_on(1, 1, 24100);
    chk(16'(n >= 11990 && n <= 24010), 1);
    sense_req <= 10'h000;
    wait_on(0, 0, 18100);
    repeat (50) @(posedge clk_in);
    chk(|bleed_out, 0);
    plug <= 1'b0;
    repeat (5) @(posedge clk_in);
    plug <= 1'b1;
    wait_on(0, 1, 5);
    chk(|bleed_out, 1);
    wr(8'h0a, 8'h8f);
    plug <= 1'b0;
    wait_on(0, 0, 5);
    chk(|bleed_out, 0);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, about half again the expected run
  initial begin
    #1_000_000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset;
    t_trip;
    t_short;
    t_mode1;
    t_mode3;
    tally_and_finish;
  end
endmodule
`default_nettype wire
